// ===== rtl/exec_pkg_compare.sv
// shared constants and carriers for the bit-logic / compare-branch executor,
// plus the compare-and-target unit that the executor instantiates.
// assumes a synchronous code memory answering one clock after the address.
package exec_pkg;
  // opcodes of this slice
  localparam logic [7:0] OP_AND_C_BIT = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT = 8'hb0;
  localparam logic [7:0] OP_CJ_A_DIR = 8'hb5;
  localparam logic [7:0] OP_CJ_A_IMM = 8'hb4;
  localparam logic [4:0] OP_CJ_REG_HI = 5'h17;
  localparam logic [6:0] OP_CJ_IND_HI = 7'h5b;
  localparam logic [7:0] OP_CLR_ACC = 8'he4;
  localparam logic [7:0] OP_CLR_C = 8'hc3;
  localparam logic [7:0] OP_CLR_BIT = 8'hc2;
  localparam logic [7:0] OP_CPL_ACC = 8'hf4;
  localparam logic [7:0] OP_CPL_C = 8'hb3;
  localparam logic [7:0] OP_CPL_BIT = 8'hb2;
  // instruction lengths in bytes
  localparam logic [15:0] LEN_1 = 16'h0001;
  localparam logic [15:0] LEN_2 = 16'h0002;
  localparam logic [15:0] LEN_3 = 16'h0003;
  // clocks per machine cycle; last clock index of 1- and 2-cycle instructions
  localparam int MC_CLKS = 4;
  localparam logic [2:0] LAST_1CYC = 3'(MC_CLKS - 1);
  localparam logic [2:0] LAST_2CYC = 3'(2 * MC_CLKS - 1);
  // fetch slots
  localparam logic [2:0] SLOT_OP = 3'h1;
  localparam logic [2:0] SLOT_B1 = 3'h2;
  localparam logic [2:0] SLOT_B2 = 3'h3;
  // direct space
  localparam int RAM_WORDS = 128;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] SFR_PORT = 8'h90;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam int CARRY_POS = 7;
  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hff;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] pc_next;
    logic [7:0] rel;
  } cmp_in_type;

  typedef struct packed {
    logic unequal;
    logic less;
    logic [15:0] target;
  } cmp_out_type;

  typedef struct packed {
    logic [2:0] t;
    logic [15:0] pc;
    logic [15:0] code_addr;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] acc;
    logic carry;
    logic [7:0] port_latch;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic done;
    logic illegal;
  } exec_state_type;
endpackage

`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module compare_target (
  // operands and displacement
  input wire exec_pkg::cmp_in_type cin,
  // result
  output exec_pkg::cmp_out_type cout
);
  always_comb begin
    cout.unequal = (cin.a != cin.b);
    cout.less = (cin.a < cin.b);
    cout.target = cin.pc_next + {{8{cin.rel[7]}}, cin.rel};
  end
endmodule // compare_target

// ===== rtl/bit_logic_compare_branch_exec.sv
// executor for bit-and into carry, compare-and-jump-unequal, clear and complement.
// assumes code memory returns code_data one clock after code_addr; one machine
// cycle is exec_pkg::MC_CLKS clocks; working registers sit in bank 0.
// How it works
// - source bit zero clears carry, else keep
// - slash form uses inverted bit, bit untouched
// - bit-and accepts only direct bit addresses
// - jump only when operands differ, operands kept
// - pc plus three, then signed displacement
// - carry set when first below second, unsigned
// - four compare forms, three bytes, two cycles
// - clear accumulator, flags unchanged, one cycle
// - clear carry or direct bit, one cycle
// - complement accumulator, flags unchanged, one cycle
// - complement carry or direct bit, one cycle
// - port complement reads output latch, not pins
`timescale 1ns/100ps

module bit_logic_compare_branch_exec (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // code memory
  output logic [15:0] code_addr,
  input wire logic [7:0] code_data,
  // port pins
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_out,
  // architectural state and status
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic [15:0] pc_out,
  output logic instr_done,
  output logic illegal_op
);
  exec_pkg::exec_state_type st, nxt;
  logic [7:0] ram_mem [exec_pkg::RAM_WORDS];
  logic ram_we;
  logic [6:0] ram_wa;
  logic [7:0] ram_wd;
  exec_pkg::cmp_in_type cin;
  exec_pkg::cmp_out_type cout;

  ////////////////////////////////////////////////////////////////////////////
  // decode; op is valid from slot 2 onward
  logic is_and, is_compare_jump_unequal, two_byte, one_byte, two_cycle, exec;
  logic [7:0] bit_byte_addr;
  logic [2:0] bit_idx;
  logic [7:0] latch_byte, pin_byte, new_byte;
  logic src_bit;

  function automatic logic [7:0] rd_direct(input logic [7:0] a, input logic use_latch,
                                           input exec_pkg::exec_state_type s);
    logic [7:0] v;
    v = 8'h00;
    if (a < exec_pkg::SFR_BASE) v = ram_mem[a[6:0]];
    else if (a == exec_pkg::SFR_PORT) v = use_latch ? s.port_latch : s.pin_s2;
    else if (a == exec_pkg::SFR_PSW) v = {s.carry, 7'h00};
    else if (a == exec_pkg::SFR_ACC) v = s.acc;
    return v;
  endfunction

  always_comb begin
    is_and = (st.op == exec_pkg::OP_AND_C_BIT) || (st.op == exec_pkg::OP_AND_C_NBIT);
    is_compare_jump_unequal = (st.op == exec_pkg::OP_CJ_A_DIR) || (st.op == exec_pkg::OP_CJ_A_IMM)
      || (st.op[7:3] == exec_pkg::OP_CJ_REG_HI) || (st.op[7:1] == exec_pkg::OP_CJ_IND_HI);
    two_byte = is_and || (st.op == exec_pkg::OP_CLR_BIT) || (st.op == exec_pkg::OP_CPL_BIT);
    one_byte = (st.op == exec_pkg::OP_CLR_ACC) || (st.op == exec_pkg::OP_CLR_C)
      || (st.op == exec_pkg::OP_CPL_ACC) || (st.op == exec_pkg::OP_CPL_C);
    two_cycle = is_and || is_compare_jump_unequal;
    exec = (st.t == (two_cycle ? exec_pkg::LAST_2CYC : exec_pkg::LAST_1CYC));
    // low bit addresses land in the bit-addressable ram, high ones in registers
    bit_idx = st.b1[2:0];
    bit_byte_addr = st.b1[7] ? {st.b1[7:3], 3'h0}
                             : exec_pkg::BIT_RAM_BASE + {4'h0, st.b1[6:3]};
    latch_byte = rd_direct(bit_byte_addr, 1'b1, st);
    pin_byte = rd_direct(bit_byte_addr, 1'b0, st);
    src_bit = pin_byte[bit_idx] ^ (st.op == exec_pkg::OP_AND_C_NBIT);
    new_byte = latch_byte;
    new_byte[bit_idx] = (st.op == exec_pkg::OP_CPL_BIT) ? ~latch_byte[bit_idx] : 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare operands
  always_comb begin
    cin.pc_next = st.pc + exec_pkg::LEN_3;
    cin.rel = st.b2;
    cin.b = st.b1;
    if (st.op[7:3] == exec_pkg::OP_CJ_REG_HI) cin.a = ram_mem[{4'h0, st.op[2:0]}];
    else if (st.op[7:1] == exec_pkg::OP_CJ_IND_HI) cin.a = ram_mem[ram_mem[{6'h00, st.op[0]}][6:0]];
    else cin.a = st.acc;
    // a direct port operand is what the pins show
    if (st.op == exec_pkg::OP_CJ_A_DIR) cin.b = rd_direct(st.b1, 1'b0, st);
  end

  compare_target u_cmp (
    .cin(cin),
    .cout(cout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt = st;
    nxt.done = 1'b0;
    nxt.illegal = 1'b0;
    nxt.pin_s1 = port_pin_in;
    nxt.pin_s2 = st.pin_s1;
    nxt.t = st.t + 3'h1;
    nxt.code_addr = st.code_addr + 16'h0001;
    ram_we = 1'b0;
    ram_wa = 7'h00;
    ram_wd = 8'h00;
    case (st.t)
      exec_pkg::SLOT_OP: nxt.op = code_data;
      exec_pkg::SLOT_B1: nxt.b1 = code_data;
      exec_pkg::SLOT_B2: nxt.b2 = code_data;
      default: ;
    endcase
    if (exec) begin
      nxt.t = 3'h0;
      nxt.done = 1'b1;
      nxt.pc = st.pc + (is_compare_jump_unequal ? exec_pkg::LEN_3 : two_byte ? exec_pkg::LEN_2 : exec_pkg::LEN_1);
      if (is_compare_jump_unequal) begin
        nxt.carry = cout.less;
        if (cout.unequal) nxt.pc = cout.target;
      end else if (is_and) begin
        if (!src_bit) nxt.carry = 1'b0;
      end else if (st.op == exec_pkg::OP_CLR_ACC) begin
        nxt.acc = 8'h00;
      end else if (st.op == exec_pkg::OP_CPL_ACC) begin
        nxt.acc = ~st.acc;
      end else if (st.op == exec_pkg::OP_CLR_C) begin
        nxt.carry = 1'b0;
      end else if (st.op == exec_pkg::OP_CPL_C) begin
        nxt.carry = ~st.carry;
      end else if ((st.op == exec_pkg::OP_CLR_BIT) || (st.op == exec_pkg::OP_CPL_BIT)) begin
        // writes to unmodelled registers are dropped
        if (bit_byte_addr < exec_pkg::SFR_BASE) begin
          ram_we = 1'b1;
          ram_wa = bit_byte_addr[6:0];
          ram_wd = new_byte;
        end else if (bit_byte_addr == exec_pkg::SFR_PORT) nxt.port_latch = new_byte;
        else if (bit_byte_addr == exec_pkg::SFR_PSW) nxt.carry = new_byte[exec_pkg::CARRY_POS];
        else if (bit_byte_addr == exec_pkg::SFR_ACC) nxt.acc = new_byte;
      end else if (!one_byte) begin
        nxt.illegal = 1'b1;
      end
      nxt.code_addr = nxt.pc;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.pc <= exec_pkg::PC_RST;
      st.code_addr <= exec_pkg::PC_RST;
      st.acc <= exec_pkg::ACC_RST;
      st.port_latch <= exec_pkg::PORT_RST;
    end else begin
      st <= nxt;
    end
  end

  // ram clears at reset: register and indirect compares never see unknown data,
  // at the price of no longer mapping onto block memory
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < exec_pkg::RAM_WORDS; i++) ram_mem[i] <= 8'h00;
    end else if (ram_we) begin
      ram_mem[ram_wa] <= ram_wd;
    end
  end

  assign code_addr = st.code_addr;
  assign port_out = st.port_latch;
  assign acc_out = st.acc;
  assign carry_out = st.carry;
  assign pc_out = st.pc;
  assign instr_done = st.done;
  assign illegal_op = st.illegal;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic cpl_port_bit;
  assign cpl_port_bit = exec && (st.op == exec_pkg::OP_CPL_BIT) && (bit_byte_addr == exec_pkg::SFR_PORT);

  property p_and_clears;
    exec && is_and && !src_bit |=> !carry_out ##0 pc_out == $past(pc_out) + 16'h0002;
  endproperty
  a_and_clears: assert property (p_and_clears) else $error("bit-and did not clear carry");

  property p_and_keeps;
    exec && is_and && src_bit |=> $stable(carry_out) && $stable(port_out) && $stable(acc_out);
  endproperty
  a_and_keeps: assert property (p_and_keeps) else $error("bit-and changed state");

  property p_and_len;
    exec && is_and |=> pc_out == $past(pc_out) + 16'h0002 && !illegal_op;
  endproperty
  a_and_len: assert property (p_and_len) else $error("bit-and length wrong");

  property p_compare_jump_unequal_eq;
    exec && is_compare_jump_unequal && !cout.unequal |=> pc_out == $past(pc_out) + 16'h0003 && $stable(acc_out);
  endproperty
  a_compare_jump_unequal_eq: assert property (p_compare_jump_unequal_eq) else $error("equal compare jumped");

  property p_compare_jump_unequal_jump;
    exec && is_compare_jump_unequal && cout.unequal |=>
      pc_out == $past(pc_out) + 16'h0003 + {{8{$past(st.b2[7])}}, $past(st.b2)};
  endproperty
  a_compare_jump_unequal_jump: assert property (p_compare_jump_unequal_jump) else $error("jump target wrong");

  property p_compare_jump_unequal_carry;
    exec && is_compare_jump_unequal |=> carry_out == $past(cin.a < cin.b);
  endproperty
  a_compare_jump_unequal_carry: assert property (p_compare_jump_unequal_carry) else $error("compare carry wrong");

  property p_compare_jump_unequal_time;
    st.t == exec_pkg::SLOT_B2 && is_compare_jump_unequal |=> !instr_done [*4] ##1 instr_done;
  endproperty
  a_compare_jump_unequal_time: assert property (p_compare_jump_unequal_time) else $error("compare not two cycles");

  property p_clr_acc;
    exec && st.op == exec_pkg::OP_CLR_ACC |=> acc_out == 8'h00 && $stable(carry_out);
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("accumulator clear wrong");

  property p_clr_c;
    st.t == exec_pkg::SLOT_B2 && st.op == exec_pkg::OP_CLR_C |=> !carry_out && instr_done;
  endproperty
  a_clr_c: assert property (p_clr_c) else $error("carry clear wrong");

  property p_cpl_acc;
    exec && st.op == exec_pkg::OP_CPL_ACC |=> acc_out == ~$past(acc_out) && $stable(carry_out);
  endproperty
  a_cpl_acc: assert property (p_cpl_acc) else $error("accumulator complement wrong");

  property p_cpl_c;
    exec && st.op == exec_pkg::OP_CPL_C |=> carry_out != $past(carry_out);
  endproperty
  a_cpl_c: assert property (p_cpl_c) else $error("carry complement wrong");

  property p_cpl_port;
    cpl_port_bit |=> port_out == ($past(port_out) ^ (8'h01 << $past(bit_idx)));
  endproperty
  a_cpl_port: assert property (p_cpl_port) else $error("port complement used pins");

  c_jump: cover property (exec && is_compare_jump_unequal && cout.unequal);
  c_and_clear: cover property (exec && is_and && !src_bit);
  c_cpl_port: cover property (cpl_port_bit);
endmodule // bit_logic_compare_branch_exec

// ===== bench/code_rom.sv
// code memory model feeding the executor's fetch port
// assumes code_addr is launched on the rising edge of clk
`timescale 1ns/100ps

module code_rom (
  // clock
  input wire logic clk,
  // fetch
  input wire logic [15:0] addr,
  output logic [7:0] data
);
  logic [7:0] mem [256];

  // one clock latency; low address byte only, bench programs stay small
  always_ff @(posedge clk) begin
    data <= mem[addr[7:0]];
  end
endmodule // code_rom

// ===== bench/tb.sv
// self-checking bench for the bit-logic / compare-branch executor
// assumes the code_rom model on the fetch port and a 50 MHz clock
`timescale 1ns/100ps

module tb;
  logic clk;
  logic nrst;
  logic [15:0] code_addr;
  logic [7:0] code_data;
  logic [7:0] pins;
  logic [7:0] port_out;
  logic [7:0] acc_out;
  logic carry_out;
  logic [15:0] pc_out;
  logic instr_done;
  logic illegal_op;
  int miscompares;
  int samples_checked;

  bit_logic_compare_branch_exec bit_logic_compare_branch_exec_inst (
    .clk(clk), .nrst(nrst), .code_addr(code_addr), .code_data(code_data),
    .port_pin_in(pins), .port_out(port_out), .acc_out(acc_out), .carry_out(carry_out),
    .pc_out(pc_out), .instr_done(instr_done), .illegal_op(illegal_op));
  code_rom code_rom_inst (.clk(clk), .addr(code_addr), .data(code_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // unused code bytes hold an opcode outside the slice
  task automatic start(input logic [7:0] pin_val);
    nrst = 1'b0;
    pins = pin_val;
    foreach (code_rom_inst.mem[i]) code_rom_inst.mem[i] = 8'ha5;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
  endtask

  task automatic put(input logic [7:0] at, input logic [7:0] b[$]);
    foreach (b[i]) code_rom_inst.mem[at + 8'(i)] = b[i];
  endtask

  // gap is counted from the previous done pulse; cyc 0 skips it
  task automatic step(input int cyc, input logic ill, input logic [7:0] a_e,
                      input logic c_e, input logic [15:0] pc_e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (instr_done !== 1'b1 && n < 40);
    if (cyc > 0) check(16'(n), 16'(4 * cyc), "clocks");
    check(16'(illegal_op), 16'(ill), "illegal");
    check(16'(acc_out), 16'(a_e), "acc");
    check(16'(carry_out), 16'(c_e), "carry");
    check(pc_out, pc_e, "pc");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_acc_carry;
    start(8'h00);
    put(8'h00, '{8'hb3, 8'hf4, 8'he4, 8'hf4, 8'hc3, 8'hb3});
    step(0, 1'b0, 8'h00, 1'b1, 16'h0001);
    step(1, 1'b0, 8'hff, 1'b1, 16'h0002);
    step(1, 1'b0, 8'h00, 1'b1, 16'h0003);
    step(1, 1'b0, 8'hff, 1'b1, 16'h0004);
    step(1, 1'b0, 8'hff, 1'b0, 16'h0005);
    step(1, 1'b0, 8'hff, 1'b1, 16'h0006);
    step(1, 1'b1, 8'hff, 1'b1, 16'h0007);
    $display("test acc_carry done");
  endtask

  task automatic t_bit_and;
    start(8'hfe);
    put(8'h00, '{8'hb3, 8'h82, 8'he7, 8'hb3, 8'hf4, 8'h82, 8'he7, 8'hb0, 8'he7,
                 8'hb3, 8'h82, 8'h90, 8'hb3, 8'h82, 8'h91});
    step(0, 1'b0, 8'h00, 1'b1, 16'h0001);
    step(2, 1'b0, 8'h00, 1'b0, 16'h0003);
    step(1, 1'b0, 8'h00, 1'b1, 16'h0004);
    step(1, 1'b0, 8'hff, 1'b1, 16'h0005);
    step(2, 1'b0, 8'hff, 1'b1, 16'h0007);
    step(2, 1'b0, 8'hff, 1'b0, 16'h0009);
    step(1, 1'b0, 8'hff, 1'b1, 16'h000a);
    step(2, 1'b0, 8'hff, 1'b0, 16'h000c);
    step(1, 1'b0, 8'hff, 1'b1, 16'h000d);
    step(2, 1'b0, 8'hff, 1'b1, 16'h000f);
    $display("test bit_and done");
  endtask

  // ram reads zero after reset: register and indirect forms compare 0 against k
  task automatic t_compare_jump_unequal;
    logic [7:0] ops[$] = '{8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
                           8'hb6, 8'hb7};
    start(8'h34);
    put(8'h00, '{8'hb4, 8'h00, 8'h10, 8'hb4, 8'h01, 8'h0a, 8'hb5, 8'he0, 8'h40,
                 8'hb5, 8'h90, 8'h14});
    put(8'h10, '{8'hf4, 8'hb4, 8'h05, 8'hf2});
    put(8'h20, '{8'hf4, 8'hb5, 8'h90, 8'h02});
    foreach (ops[k]) put(8'h26 + 8'(3 * k), '{ops[k], 8'(k), 8'h00});
    step(0, 1'b0, 8'h00, 1'b0, 16'h0003);
    step(2, 1'b0, 8'h00, 1'b1, 16'h0010);
    step(1, 1'b0, 8'hff, 1'b1, 16'h0011);
    step(2, 1'b0, 8'hff, 1'b0, 16'h0006);
    step(2, 1'b0, 8'hff, 1'b0, 16'h0009);
    step(2, 1'b0, 8'hff, 1'b0, 16'h0020);
    step(1, 1'b0, 8'h00, 1'b0, 16'h0021);
    step(2, 1'b0, 8'h00, 1'b1, 16'h0026);
    foreach (ops[k]) step(2, 1'b0, 8'h00, k != 0, 16'h0029 + 16'(3 * k));
    $display("test compare_jump_unequal done");
  endtask

  // pins held low so a pin read instead of the latch shows up
  task automatic t_bit_write;
    start(8'h00);
    put(8'h00, '{8'hb2, 8'h91, 8'hc2, 8'h92, 8'hb2, 8'h91, 8'hb2, 8'hd7, 8'hc2, 8'hd7,
                 8'hf4, 8'hc2, 8'he0, 8'hb2, 8'he7});
    step(0, 1'b0, 8'h00, 1'b0, 16'h0002);
    check(16'(port_out), 16'h00fd, "port");
    step(1, 1'b0, 8'h00, 1'b0, 16'h0004);
    check(16'(port_out), 16'h00f9, "port");
    step(1, 1'b0, 8'h00, 1'b0, 16'h0006);
    check(16'(port_out), 16'h00fb, "port");
    step(1, 1'b0, 8'h00, 1'b1, 16'h0008);
    step(1, 1'b0, 8'h00, 1'b0, 16'h000a);
    step(1, 1'b0, 8'hff, 1'b0, 16'h000b);
    step(1, 1'b0, 8'hfe, 1'b0, 16'h000d);
    step(1, 1'b0, 8'h7e, 1'b0, 16'h000f);
    $display("test bit_write done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    pins = 8'h00;
    miscompares = 0;
    samples_checked = 0;
    t_acc_carry;
    t_bit_and;
    t_compare_jump_unequal;
    t_bit_write;
    summarize;
  end

  // about 10000 clocks, far beyond the few hundred the tests need
  initial begin
    #200000;
    miscompares++;
    summarize;
  end
endmodule // tb
